// *** rtl/conversion_readout.sv ***
// two-wire slave that starts conversions and returns the 24-bit result
`timescale 1ns/1ps
`default_nettype none
module conversion_readout
	import sensor_readout_pkg::*;
(
	input wire logic clk,                     // 100 MHz system clock
	input wire logic rst,                     // synchronous, active high
	input wire logic scl_i,                   // serial clock pin level
	input wire logic sda_i,                   // serial data pin level
	output logic sda_o,                       // serial data drive value, always low
	output logic sda_oe_n,                    // low while pulling the data line low
	output logic conv_start,                  // one-cycle request to the converter
	output logic conv_temp,                   // 1: temperature, 0: pressure
	output logic [2:0] conv_osr,              // oversampling_ratio code of the request
	output logic conv_busy,                   // conversion in progress
	input wire logic adc_valid,               // converter result offered
	output logic adc_ready,                   // result buffer has room
	input wire logic [RESULT_W-1:0] adc_data  // converter result word
);

	// ***************************************************************
	// pin synchronisers and edge detection
	// ***************************************************************
	logic scl_ff1_q, scl_ff2_q, scl_ff3_q;   // clock pin chain
	logic sda_ff1_q, sda_ff2_q, sda_ff3_q;   // data pin chain
	logic scl_q, sda_q;                      // accepted levels
	logic scl_d, sda_d;                      // levels accepted this cycle
	logic scl_rise, scl_fall;                // clock edges
	logic start_cond, stop_cond;             // bus conditions

	// three-stage chains; only the second stage reads the first
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_ff1_q <= 1'b1;
			scl_ff2_q <= 1'b1;
			scl_ff3_q <= 1'b1;
			sda_ff1_q <= 1'b1;
			sda_ff2_q <= 1'b1;
			sda_ff3_q <= 1'b1;
		end else begin
			scl_ff1_q <= scl_i;
			scl_ff2_q <= scl_ff1_q;
			scl_ff3_q <= scl_ff2_q;
			sda_ff1_q <= sda_i;
			sda_ff2_q <= sda_ff1_q;
			sda_ff3_q <= sda_ff2_q;
		end
	end

	// a level change counts only once stages two and three agree
	assign scl_d = (scl_ff2_q == scl_ff3_q) ? scl_ff3_q : scl_q;
	assign sda_d = (sda_ff2_q == sda_ff3_q) ? sda_ff3_q : sda_q;

	// accepted levels, idle bus reads high
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
		end
	end

	assign scl_rise = ~scl_q & scl_d;
	assign scl_fall = scl_q & ~scl_d;
	// data moving while the clock stays high marks start or stop
	assign start_cond = scl_q & scl_d & sda_q & ~sda_d;
	assign stop_cond = scl_q & scl_d & ~sda_q & sda_d;

	// ***************************************************************
	// serial protocol engine
	// ***************************************************************
	link_state_t state_q;                    // protocol state
	logic [7:0] shift_q;                     // received byte
	logic [3:0] bit_cnt_q;                   // bits taken or sent in this byte
	logic [1:0] byte_idx_q;                  // result byte being sent
	logic rw_q;                              // 1: read access addressed
	logic host_ack_q;                        // host pulled data low in ack slot
	logic cmd_done;                          // command byte complete, pulse
	logic is_conv;                           // command byte is a conversion
	logic is_read;                           // command byte is an ADC read

	assign cmd_done = (state_q == ST_CMD) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);

	// conversion codes: nibble 4 or 5, even, oversampling code 0..5
	assign is_conv = ((shift_q[7:4] == CMD_PRESSURE_HI) || (shift_q[7:4] == CMD_TEMP_HI))
		&& !shift_q[0] && (shift_q[3:1] <= OSR_CODE_MAX);
	assign is_read = (shift_q == CMD_ADC_READ);

	// state transitions; start and stop win over any byte in flight
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else if (start_cond) begin
			state_q <= ST_ADDR;
		end else if (stop_cond) begin
			state_q <= ST_IDLE;
		end else if (scl_fall) begin
			unique case (state_q)
				ST_IDLE: begin
					state_q <= ST_IDLE;
				end
				ST_ADDR: begin
					// answer only our address, ignore other slaves
					if (bit_cnt_q == BITS_PER_BYTE) begin
						state_q <= (shift_q[7:1] == SLAVE_ADDR) ? ST_ADDR_ACK : ST_IDLE;
					end
				end
				ST_ADDR_ACK: begin
					state_q <= rw_q ? ST_TX : ST_CMD;
				end
				ST_CMD: begin
					if (bit_cnt_q == BITS_PER_BYTE) begin
						state_q <= ST_CMD_ACK;
					end
				end
				ST_CMD_ACK: begin
					// one command per write; further bytes go unanswered
					state_q <= ST_IDLE;
				end
				ST_TX: begin
					// pause for the acknowledge after eight bits
					if (bit_cnt_q == BITS_PER_BYTE - 4'h1) begin
						state_q <= ST_TX_ACK;
					end
				end
				ST_TX_ACK: begin
					// continue only on acknowledge with bytes left
					if (host_ack_q && (byte_idx_q != LAST_BYTE_IDX)) begin
						state_q <= ST_TX;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// bit counter: counts rises while receiving, falls while sending
	always_ff @(posedge clk) begin
		if (rst) begin
			bit_cnt_q <= 4'h0;
		end else if (start_cond) begin
			bit_cnt_q <= 4'h0;
		end else if (scl_rise && ((state_q == ST_ADDR) || (state_q == ST_CMD))) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end else if (scl_fall) begin
			if (state_q == ST_TX) begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end else if ((state_q == ST_ADDR_ACK) || (state_q == ST_TX_ACK)) begin
				bit_cnt_q <= 4'h0;
			end
		end
	end

	// receive shifter, first bit lands in the top
	always_ff @(posedge clk) begin
		if (rst) begin
			shift_q <= 8'h00;
		end else if (scl_rise && ((state_q == ST_ADDR) || (state_q == ST_CMD))) begin
			shift_q <= {shift_q[6:0], sda_d};
		end
	end

	// direction bit of the address byte
	always_ff @(posedge clk) begin
		if (rst) begin
			rw_q <= 1'b0;
		end else if ((state_q == ST_ADDR) && scl_fall && (bit_cnt_q == BITS_PER_BYTE)) begin
			rw_q <= shift_q[0];
		end
	end

	// host acknowledge sampled on the ack-slot rise
	always_ff @(posedge clk) begin
		if (rst) begin
			host_ack_q <= 1'b0;
		end else if ((state_q == ST_TX_ACK) && scl_rise) begin
			host_ack_q <= ~sda_d;
		end
	end

	// result byte index, restarted by each addressing
	always_ff @(posedge clk) begin
		if (rst) begin
			byte_idx_q <= 2'h0;
		end else if (state_q == ST_ADDR_ACK) begin
			byte_idx_q <= 2'h0;
		end else if ((state_q == ST_TX_ACK) && scl_fall && host_ack_q
			&& (byte_idx_q != LAST_BYTE_IDX)) begin
			byte_idx_q <= byte_idx_q + 2'h1;
		end
	end

	// ***************************************************************
	// data line drive
	// ***************************************************************
	logic [7:0] tx_byte;                     // byte on the wire now
	logic tx_bit;                            // bit on the wire now
	logic drive_low;                         // pull the line low
	logic sda_oe_n_q;                        // registered enable
	logic [RESULT_W-1:0] tx_word_q;          // word latched for readout

	always_comb begin
		unique case (byte_idx_q)
			2'h0: tx_byte = tx_word_q[23:16];
			2'h1: tx_byte = tx_word_q[15:8];
			default: tx_byte = tx_word_q[7:0];
		endcase
	end

	// most significant bit goes first
	assign tx_bit = tx_byte[3'(4'h7 - bit_cnt_q)];

	always_comb begin
		unique case (state_q)
			ST_ADDR_ACK, ST_CMD_ACK: drive_low = 1'b1;
			ST_TX: drive_low = ~tx_bit;
			default: drive_low = 1'b0;
		endcase
	end

	// registered so the pin never glitches; two clocks after the scl_fall pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			sda_oe_n_q <= 1'b1;
		end else begin
			sda_oe_n_q <= ~drive_low;
		end
	end

	assign sda_oe_n = sda_oe_n_q;
	assign sda_o = 1'b0;   // open drain: only ever pulls low

	// ***************************************************************
	// conversion sequencing and result bookkeeping
	// ***************************************************************
	logic fifo_valid;                        // a finished word is waiting
	logic fifo_pop;                          // accept it as conversion end
	logic [RESULT_W-1:0] fifo_data;          // finished word
	logic busy_q;                            // conversion running
	logic corrupt_q;                         // running conversion was disturbed
	logic result_valid_q;                    // result may be read once
	logic [RESULT_W-1:0] result_q;           // last finished result
	logic conv_start_q;
	logic conv_temp_q;
	logic [2:0] conv_osr_q;

	// words are drained only during a conversion, so the buffer can fill
	assign fifo_pop = fifo_valid & busy_q;

	word_fifo #(
		.WIDTH(RESULT_W),
		.DEPTH(FIFO_DEPTH)
	) u_result_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(adc_valid),
		.in_ready(adc_ready),
		.in_data(adc_data),
		.out_valid(fifo_valid),
		.out_ready(busy_q),
		.out_data(fifo_data)
	);

	// request to the converter; ignored while already busy
	always_ff @(posedge clk) begin
		if (rst) begin
			conv_start_q <= 1'b0;
			conv_temp_q <= 1'b0;
			conv_osr_q <= OSR_RST;
		end else begin
			conv_start_q <= 1'b0;
			if (cmd_done && is_conv && !busy_q) begin
				conv_start_q <= 1'b1;
				conv_temp_q <= (shift_q[7:4] == CMD_TEMP_HI);
				conv_osr_q <= shift_q[3:1];
			end
		end
	end

	// busy from the accepted command until the finished word arrives
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else if (cmd_done && is_conv && !busy_q) begin
			busy_q <= 1'b1;
		end else if (fifo_pop) begin
			busy_q <= 1'b0;
		end
	end

	// overlapping command or early read spoils the running result
	always_ff @(posedge clk) begin
		if (rst) begin
			corrupt_q <= 1'b0;
		end else if (cmd_done && is_conv && !busy_q) begin
			corrupt_q <= 1'b0;
		end else if (cmd_done && busy_q && (is_conv || is_read)) begin
			corrupt_q <= 1'b1;
		end
	end

	// finished result; a spoiled one is never handed out
	always_ff @(posedge clk) begin
		if (rst) begin
			result_q <= RESULT_RST;
			result_valid_q <= 1'b0;
		end else if (fifo_pop) begin
			result_q <= fifo_data;
			result_valid_q <= ~(corrupt_q | (cmd_done & (is_conv | is_read)));
		end else if (cmd_done && (is_read || is_conv)) begin
			result_valid_q <= 1'b0;
		end
	end

	// read command latches the word the next read access shifts out
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_word_q <= RESULT_RST;
		end else if (cmd_done && is_read) begin
			if (busy_q || !result_valid_q) begin
				tx_word_q <= RESULT_RST;
			end else begin
				tx_word_q <= result_q;
			end
		end
	end

	assign conv_start = conv_start_q;
	assign conv_temp = conv_temp_q;
	assign conv_osr = conv_osr_q;
	assign conv_busy = busy_q;

endmodule
`default_nettype wire

// *** common/sensor_readout_pkg.sv ***
// constants, state encoding, widths and reset values shared by the sensor readout design
// Operation
// - conversion command starts one pressure or temperature conversion
// - after completion, read shifts result out MSB first
// - read without prior conversion returns zero
// - repeated read without new conversion returns zero
// - read during conversion returns zero, result corrupted
// - conversion command during conversion yields wrong result
// - busy from command until conversion finishes
// - acknowledge bit follows every eight data bits
// - answer seven-bit address 1110110, R/W last
// - one-byte commands: 0x40-0x4A, 0x50-0x5A, read 0x00
package sensor_readout_pkg;

	// ***************************************************************
	// bus addressing and command codes
	// ***************************************************************
	localparam logic [6:0] SLAVE_ADDR = 7'h76;          // 1110110
	localparam logic [7:0] CMD_ADC_READ = 8'h00;        // fetch conversion result
	localparam logic [3:0] CMD_PRESSURE_HI = 4'h4;      // upper nibble, raw_pressure_conversion
	localparam logic [3:0] CMD_TEMP_HI = 4'h5;          // upper nibble, raw_temperature_conversion
	localparam logic [2:0] OSR_CODE_MAX = 3'h5;         // highest oversampling_ratio code

	// ***************************************************************
	// widths, counts and reset values
	// ***************************************************************
	localparam int RESULT_W = 24;                       // conversion result width
	localparam int FIFO_DEPTH = 32;                     // words buffered from the converter
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;        // data bits between acknowledges
	localparam logic [1:0] LAST_BYTE_IDX = 2'h2;        // three result bytes, index 0..2
	localparam logic [23:0] RESULT_RST = 24'h000000;    // result value after reset and on error
	localparam logic [2:0] OSR_RST = 3'h0;              // oversampling code after reset

	// ***************************************************************
	// serial protocol states
	// ***************************************************************
	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,   // waiting for a start condition
		ST_ADDR     = 3'b001,   // shifting in address byte
		ST_ADDR_ACK = 3'b010,   // driving address acknowledge
		ST_CMD      = 3'b011,   // shifting in command byte
		ST_CMD_ACK  = 3'b100,   // driving command acknowledge
		ST_TX       = 3'b101,   // shifting out a result byte
		ST_TX_ACK   = 3'b110    // listening for the host acknowledge
	} link_state_t;

endpackage

// *** rtl/word_fifo.sv ***
// synchronous word fifo with registered read data and show-ahead output
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];   // storage
	logic [AW-1:0] wr_ptr_q;           // next slot to write
	logic [AW-1:0] rd_ptr_q;           // slot shown at the output
	logic [AW:0] count_q;              // words held
	logic [AW-1:0] rd_next;            // read pointer after this cycle
	logic push;
	logic pop;
	logic [WIDTH-1:0] rdata_q;         // registered head word

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign rd_next = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
	assign out_data = rdata_q;

	// storage write, no reset needed on the array
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			rd_ptr_q <= rd_next;
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// head register; bypass covers a write into the slot about to be shown
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (push && (wr_ptr_q == rd_next)) begin
			rdata_q <= in_data;
		end else begin
			rdata_q <= mem_q[rd_next];
		end
	end
endmodule
`default_nettype wire

// *** testbench/conversion_readout_chk.sv ***
// port-level assertion checker for the conversion readout slave
`timescale 1ns/1ps
`default_nettype none
module conversion_readout_chk
	import sensor_readout_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic conv_start,
	input wire logic conv_temp,
	input wire logic [2:0] conv_osr,
	input wire logic conv_busy,
	input wire logic adc_valid,
	input wire logic adc_ready,
	input wire logic [RESULT_W-1:0] adc_data
);
	// ***************************************************************
	// buffer occupancy seen from outside
	// ***************************************************************
	logic [6:0] held_q; // pushes minus ended conversions; may lag the buffer by one clock

	// count accepted words, drop one each time a conversion ends
	always_ff @(posedge clk) begin
		if (rst) begin
			held_q <= 7'h00;
		end else begin
			held_q <= held_q + 7'(adc_valid && adc_ready) - 7'($fell(conv_busy));
		end
	end

	// ***************************************************************
	// properties
	// ***************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_launch; conv_start; endsequence            // converter request
	sequence s_word_in; adc_valid && adc_ready; endsequence // word accepted

	property p_start_busy; s_launch |-> ##[0:1] conv_busy; endproperty
	property p_start_pulse; s_launch |=> !conv_start; endproperty
	property p_no_restart; $past(conv_busy) |-> !conv_start; endproperty
	property p_osr_range; s_launch |-> conv_osr <= OSR_CODE_MAX; endproperty
	property p_cfg_stable;
		conv_busy && $past(conv_busy) |-> $stable(conv_temp) && $stable(conv_osr);
	endproperty
	property p_full_refuse; !adc_ready |-> held_q >= 7'h20; endproperty
	property p_busy_ends; $fell(conv_busy) |-> held_q != 7'h00; endproperty
	property p_word_ends_busy; conv_busy ##0 s_word_in |-> ##[1:3] !conv_busy; endproperty

	a_start_busy: assert property (p_start_busy)
		else $error("conversion request without busy");
	a_start_pulse: assert property (p_start_pulse)
		else $error("conversion request longer than one clock");
	a_no_restart: assert property (p_no_restart)
		else $error("conversion started while busy");
	a_osr_range: assert property (p_osr_range)
		else $error("oversampling code out of range");
	a_cfg_stable: assert property (p_cfg_stable)
		else $error("conversion selection changed while busy");
	a_full_refuse: assert property (p_full_refuse)
		else $error("buffer refused words while not full");
	a_busy_ends: assert property (p_busy_ends)
		else $error("busy ended with no word held");
	a_word_ends_busy: assert property (p_word_ends_busy)
		else $error("busy stayed after result arrived");
endmodule

bind conversion_readout conversion_readout_chk conversion_readout_chk_inst (.clk(clk), .rst(rst),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .conv_start(conv_start),
	.conv_temp(conv_temp), .conv_osr(conv_osr), .conv_busy(conv_busy), .adc_valid(adc_valid),
	.adc_ready(adc_ready), .adc_data(adc_data));
`default_nettype wire

// *** testbench/i2c_host.sv ***
// behavioural two-wire host that clocks commands and results on clk falling edges
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
	input wire logic clk,
	input wire logic sda,      // resolved data line level
	output var logic scl,      // serial clock, stands high outside frames
	output var logic sda_h     // host drive, 1 = released to the pull-up
);
	// ***************************************************************
	// bit level, eight clocks per bit, six low and two high
	// the slave answer lands about five clocks after a fall, so the low
	// phase must outlast it or the answer would move while the clock is high
	// ***************************************************************
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// data changes only mid-low phase so it never looks like start or stop
	task automatic bit_out(input logic b);
		tick(2);
		sda_h = b;
		tick(4);
		scl = 1'b1;
		tick(2);
		scl = 1'b0;
	endtask

	// sample late in the high phase, the slave drive lands some clocks after the fall
	task automatic bit_in(output logic b);
		tick(2);
		sda_h = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(1);
		b = sda;
		tick(1);
		scl = 1'b0;
	endtask

	// ***************************************************************
	// framing and bytes
	// ***************************************************************
	task automatic start();
		tick(4);
		sda_h = 1'b0;
		tick(4);
		scl = 1'b0;
	endtask

	task automatic stop();
		tick(2);
		sda_h = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_h = 1'b1;
		tick(4);
	endtask

	// msb first, ack is 1 when the slave pulled the line low
	task automatic write_byte(input logic [7:0] v, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_out(v[i]);
		end
		bit_in(b);
		ack = ~b;
	endtask

	// eight data bits then the host acknowledge, released on the last byte
	task automatic read_byte(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			bit_in(v[i]);
		end
		bit_out(last);
	endtask
endmodule
`default_nettype wire

// *** testbench/pressure_temp_conversion_readout_bench.sv ***
// self-checking bench for the conversion readout slave and its result buffer
`timescale 1ns/1ps
`default_nettype none
module pressure_temp_conversion_readout_bench
	import sensor_readout_pkg::*;
;
	logic clk, rst, adc_valid, sda_o, sda_oe_n, conv_start, conv_temp, conv_busy, adc_ready;
	logic scl, sda_h, ack;
	logic [2:0] conv_osr;
	logic [RESULT_W-1:0] adc_data, v;
	wire logic sda_w = sda_h & (sda_oe_n | sda_o); // open drain with pull-up
	int num_errors = 0;
	int check_count = 0;
	// rows: command, expected temperature select, expected oversampling code
	localparam logic [11:0] ROWS [12] = '{12'h400, 12'h421, 12'h442, 12'h463, 12'h484,
		12'h4A5, 12'h508, 12'h529, 12'h54A, 12'h56B, 12'h58C, 12'h5AD};

	conversion_readout conversion_readout_inst (.clk(clk), .rst(rst), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .conv_start(conv_start),
		.conv_temp(conv_temp), .conv_osr(conv_osr), .conv_busy(conv_busy),
		.adc_valid(adc_valid), .adc_ready(adc_ready), .adc_data(adc_data));
	i2c_host i2c_host_inst (.clk(clk), .sda(sda_w), .scl(scl), .sda_h(sda_h));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ***************************************************************
	// helpers
	// ***************************************************************
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic send_cmd(input logic [7:0] cmd);
		i2c_host_inst.start();
		i2c_host_inst.write_byte({SLAVE_ADDR, 1'b0}, ack);
		check({23'h0, ack}, 24'h000001);
		i2c_host_inst.write_byte(cmd, ack);
		check({23'h0, ack}, 24'h000001);
		i2c_host_inst.stop();
	endtask

	// read command, then a separate read access of three bytes, last one not acknowledged
	task automatic read_result(output logic [23:0] r);
		send_cmd(CMD_ADC_READ);
		i2c_host_inst.start();
		i2c_host_inst.write_byte({SLAVE_ADDR, 1'b1}, ack);
		check({23'h0, ack}, 24'h000001);
		i2c_host_inst.read_byte(1'b0, r[23:16]);
		i2c_host_inst.read_byte(1'b0, r[15:8]);
		i2c_host_inst.read_byte(1'b1, r[7:0]);
		i2c_host_inst.stop();
	endtask

	// one word offered for exactly one rising edge, then one idle edge
	task automatic push_word(input logic [23:0] w);
		adc_valid = 1'b1;
		adc_data = w;
		@(negedge clk);
		adc_valid = 1'b0;
		@(negedge clk);
	endtask

	// bounded wait for the conversion to finish before reading
	task automatic wait_idle();
		for (int i = 0; i < 200; i++) begin
			if (conv_busy === 1'b0) return;
			@(negedge clk);
		end
		num_errors++;
		$display("CHECK FAILED at %0t: busy never ended", $time);
		finish_test();
	endtask

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		rst = 1'b1;
		adc_valid = 1'b0;
		adc_data = 24'h000000;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		// every conversion code, result returned whole
		for (int i = 0; i < 12; i++) begin
			send_cmd(ROWS[i][11:4]);
			check({23'h0, conv_busy}, 24'h000001);
			check({23'h0, conv_temp}, {23'h0, ROWS[i][3]});
			check({21'h0, conv_osr}, {21'h0, ROWS[i][2:0]});
			push_word({ROWS[i], ~ROWS[i]});
			wait_idle();
			read_result(v);
			check(v, {ROWS[i], ~ROWS[i]});
		end
		read_result(v);
		check(v, 24'h000000);
		// read in mid-conversion gives zero and spoils the result
		send_cmd(8'h48);
		read_result(v);
		check(v, 24'h000000);
		check({23'h0, conv_busy}, 24'h000001);
		push_word(24'h123456);
		wait_idle();
		read_result(v);
		check(v, 24'h000000);
		// second command while busy is ignored and spoils the result
		send_cmd(8'h40);
		send_cmd(8'h50);
		check({23'h0, conv_temp}, 24'h000000);
		push_word(24'h654321);
		wait_idle();
		read_result(v);
		check(v, 24'h000000);
		// foreign address gets no acknowledge, unknown command starts nothing
		i2c_host_inst.start();
		i2c_host_inst.write_byte(8'hA0, ack);
		check({23'h0, ack}, 24'h000000);
		i2c_host_inst.stop();
		send_cmd(8'h1E);
		check({23'h0, conv_busy}, 24'h000000);
		// oversampling code beyond the table and an odd code start nothing
		send_cmd(8'h4C);
		check({23'h0, conv_busy}, 24'h000000);
		send_cmd(8'h41);
		check({23'h0, conv_busy}, 24'h000000);
		// fill the buffer until it refuses, then drain it in order
		for (int k = 0; k < 32; k++) begin
			check({23'h0, adc_ready}, 24'h000001);
			push_word({k[7:0], ~k[7:0], 8'hC3});
		end
		check({23'h0, adc_ready}, 24'h000000);
		for (int k = 0; k < 32; k++) begin
			send_cmd(8'h5A);
			wait_idle();
			read_result(v);
			check(v, {k[7:0], ~k[7:0], 8'hC3});
		end
		check({23'h0, adc_ready}, 24'h000001);
		// reset in mid-conversion, then a read with nothing converted
		send_cmd(8'h58);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check({19'h0, sda_o, conv_busy, conv_temp, sda_oe_n, adc_ready}, 24'h000003);
		check({21'h0, conv_osr}, 24'h000000);
		read_result(v);
		check(v, 24'h000000);
		finish_test();
	end
endmodule
`default_nettype wire
